// *** src/cscr_pkg.sv ***
`default_nettype none
package cscr_pkg;

  // Register offsets and status page on the control port.
  localparam logic [7:0] CSCR_CHAN_STATUS_OFS  = 8'h79;
  localparam logic [7:0] CSCR_DEV_STATUS_OFS   = 8'h7A;
  localparam logic [7:0] CSCR_CHECKSUM_OFS     = 8'h7E;
  localparam logic [7:0] CSCR_STATUS_PAGE      = 8'h00;

  // Values after reset, and read data for unmapped addresses.
  localparam logic [7:0] CSCR_CHAN_STATUS_RST  = 8'h00;
  localparam logic [7:0] CSCR_DEV_STATUS_RST   = 8'h80;
  localparam logic [7:0] CSCR_CHECKSUM_RST     = 8'h00;
  localparam logic [7:0] CSCR_RDATA_RST        = 8'h00;
  localparam logic [7:0] CSCR_UNMAPPED_RDATA   = 8'h00;

  // Field positions in the device state register.
  localparam int CSCR_MODE_MSB     = 7;
  localparam int CSCR_MODE_LSB     = 5;
  localparam int CSCR_PLL_BIT      = 4;
  localparam int CSCR_MICBIAS_BIT  = 3;
  localparam int CSCR_BOOST_BIT    = 2;
  localparam int CSCR_IN_FLT_BIT   = 1;
  localparam int CSCR_BIAS_FLT_BIT = 0;

  // Field positions in the channel power register.
  localparam int CSCR_REC_MSB  = 7;
  localparam int CSCR_REC_LSB  = 4;
  localparam int CSCR_PLAY_MSB = 3;
  localparam int CSCR_PLAY_LSB = 0;

  typedef enum logic [2:0]
  {
    CSCR_MODE_SLEEP  = 3'h4,
    CSCR_MODE_IDLE   = 3'h6,
    CSCR_MODE_ACTIVE = 3'h7
  } cscr_mode_t;

endpackage : cscr_pkg

`default_nettype wire

// *** src/cscr_status_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module cscr_status_gen
  import cscr_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                sleep_in,
  input  wire logic                record_power_on_in,
  input  wire logic                playback_power_on_in,
  input  wire logic [CHANNELS-1:0] rec_enable_in,
  input  wire logic [CHANNELS-1:0] play_enable_in,
  input  wire logic [CHANNELS-1:0] rec_fault_down_in,
  input  wire logic                bias_fault_down_in,
  input  wire logic                pll_enable_in,
  input  wire logic                mic_bias_enable_in,
  input  wire logic                boost_enable_in,
  output logic      [7:0]          chan_status_out,
  output logic      [7:0]          dev_status_out
);

  //////////////////////////////////////////////////////////////////////////////

  logic [CHANNELS-1:0] rec_powered;
  logic [CHANNELS-1:0] play_powered;
  logic                any_powered;
  logic                input_fault_shutdown_flag;
  logic                bias_fault_shutdown_flag;
  cscr_mode_t          device_state_code;
  logic [7:0]          chan_status_next;
  logic [7:0]          dev_status_next;

  // Channel 1 sits at the highest bit of each nibble, so the index is reversed.
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++)
    begin : g_chan
      assign rec_powered[CHANNELS-1-i]  = rec_enable_in[i] & record_power_on_in & ~sleep_in
                                          & ~rec_fault_down_in[i] & ~bias_fault_down_in; // R13
      assign play_powered[CHANNELS-1-i] = play_enable_in[i] & playback_power_on_in
                                          & ~sleep_in; // R14
    end
  endgenerate

  assign any_powered = |{rec_powered, play_powered};
  assign input_fault_shutdown_flag = |rec_fault_down_in; // R8
  assign bias_fault_shutdown_flag  = bias_fault_down_in; // R9

  // Only three mode codes can ever be produced.
  assign device_state_code = sleep_in    ? CSCR_MODE_SLEEP :
                             any_powered ? CSCR_MODE_ACTIVE :
                                           CSCR_MODE_IDLE; // R3

  assign chan_status_next = {rec_powered, play_powered}; // R1 R2
  assign dev_status_next  = {device_state_code, pll_enable_in, mic_bias_enable_in,
                             boost_enable_in, input_fault_shutdown_flag,
                             bias_fault_shutdown_flag}; // R5 R6 R7

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      chan_status_out <= CSCR_CHAN_STATUS_RST; // R4
      dev_status_out  <= CSCR_DEV_STATUS_RST; // R4
    end
    else
    begin
      chan_status_out <= chan_status_next;
      dev_status_out  <= dev_status_next;
    end
  end

endmodule : cscr_status_gen

`default_nettype wire

// *** src/cscr_checksum.sv ***
`timescale 1ns/1ps
`default_nettype none

module cscr_checksum
  import cscr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       preset_in,
  input  wire logic       accumulate_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] sum_out
);

  logic [7:0] sum_next;

  // Carries beyond bit 7 are dropped on purpose: the sum is modulo 256.
  assign sum_next = preset_in     ? data_in :                 // R11
                    accumulate_in ? 8'(sum_out + addr_in + data_in) : // R15
                                    sum_out;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      sum_out <= CSCR_CHECKSUM_RST; // R11
    else
      sum_out <= sum_next; // R10
  end

endmodule : cscr_checksum

`default_nettype wire

// *** src/cscr_regs.sv ***
// Summary of operation
// R1: Record channel power states on bits 7-4.
// R2: Playback channel power states on bits 3-0.
// R3: Mode reads 4 sleep, 6 idle, 7 active.
// R4: Channel status resets to 0x00, device status to 0x80.
// R5: Bit 4 shows PLL enabled.
// R6: Bit 3 shows mic bias enabled.
// R7: Bit 2 shows boost converter enabled.
// R8: Bit 1 shows input-fault channel shutdown.
// R9: Bit 0 shows mic-bias fault shutdown.
// R10: Checksum updates on every other register write.
// R11: Writing checksum presets it; resets to zero.
// R12: Status registers are read-only; writes ignored.
// R13: Record channels powered only with record power.
// R14: Playback channels powered only with playback power.
// R15: Checksum adds address and data modulo 256.
`timescale 1ns/1ps
`default_nettype none

module cscr_regs
  import cscr_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [7:0]          reg_page_in,
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic [7:0]          reg_wdata_in,
  input  wire logic                sleep_in,
  input  wire logic                record_power_on_in,
  input  wire logic                playback_power_on_in,
  input  wire logic [CHANNELS-1:0] rec_enable_in,
  input  wire logic [CHANNELS-1:0] play_enable_in,
  input  wire logic [CHANNELS-1:0] rec_fault_down_in,
  input  wire logic                bias_fault_down_in,
  input  wire logic                pll_enable_in,
  input  wire logic                mic_bias_enable_in,
  input  wire logic                boost_enable_in,
  output logic      [7:0]          reg_rdata_out,
  output logic                     reg_rvalid_out,
  output logic      [7:0]          chan_status_out,
  output logic      [7:0]          dev_status_out,
  output logic      [7:0]          write_checksum_out
);

  //////////////////////////////////////////////////////////////////////////////

  logic       on_status_page;
  logic       hit_chan_status;
  logic       hit_dev_status;
  logic       hit_checksum;
  logic       checksum_preset;
  logic       checksum_accumulate;
  logic [7:0] rdata_sel;
  logic [7:0] reg_rdata_next;

  assign on_status_page  = reg_page_in == CSCR_STATUS_PAGE;
  assign hit_chan_status = on_status_page & (reg_addr_in == CSCR_CHAN_STATUS_OFS);
  assign hit_dev_status  = on_status_page & (reg_addr_in == CSCR_DEV_STATUS_OFS);
  assign hit_checksum    = on_status_page & (reg_addr_in == CSCR_CHECKSUM_OFS);

  // Writes on any page count, status registers included, since the host did
  // send them; only the checksum register itself is kept out of the sum.
  assign checksum_preset     = reg_wr_in & hit_checksum; // R11
  assign checksum_accumulate = reg_wr_in & ~hit_checksum; // R10 R15

  // Status addresses have no write path at all, so a write cannot disturb them.
  assign rdata_sel = hit_chan_status ? chan_status_out :
                     hit_dev_status  ? dev_status_out :
                     hit_checksum    ? write_checksum_out :
                                       CSCR_UNMAPPED_RDATA; // R12

  // A read held through a write returns the value before that write.
  assign reg_rdata_next = reg_rd_in ? rdata_sel : reg_rdata_out;

  //////////////////////////////////////////////////////////////////////////////

  cscr_status_gen #(
    .CHANNELS (CHANNELS)
  ) u_status (
    .clk_in               (clk_in),
    .sys_rst_in           (sys_rst_in),
    .sleep_in             (sleep_in),
    .record_power_on_in   (record_power_on_in),
    .playback_power_on_in (playback_power_on_in),
    .rec_enable_in        (rec_enable_in),
    .play_enable_in       (play_enable_in),
    .rec_fault_down_in    (rec_fault_down_in),
    .bias_fault_down_in   (bias_fault_down_in),
    .pll_enable_in        (pll_enable_in),
    .mic_bias_enable_in   (mic_bias_enable_in),
    .boost_enable_in      (boost_enable_in),
    .chan_status_out      (chan_status_out),
    .dev_status_out       (dev_status_out)
  );

  cscr_checksum u_checksum (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .preset_in     (checksum_preset),
    .accumulate_in (checksum_accumulate),
    .addr_in       (reg_addr_in),
    .data_in       (reg_wdata_in),
    .sum_out       (write_checksum_out)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out  <= CSCR_RDATA_RST;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out  <= reg_rdata_next;
      reg_rvalid_out <= reg_rd_in;
    end
  end

endmodule : cscr_regs

`default_nettype wire

// *** bench/cscr_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cscr_regs_props
  import cscr_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_page_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic [7:0] chan_status_out,
  input wire logic [7:0] dev_status_out,
  input wire logic [7:0] write_checksum_out
);
  wire logic       ck = reg_page_in == 8'h00 && reg_addr_in == CSCR_CHECKSUM_OFS;
  wire logic [7:0] ns = write_checksum_out + reg_addr_in + reg_wdata_in;
  wire logic [7:0] rs = reg_page_in != 8'h00 ? 8'h00 : reg_addr_in == 8'h79 ? chan_status_out :
    reg_addr_in == 8'h7A ? dev_status_out : ck ? write_checksum_out : 8'h00;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rst;
    $past(sys_rst_in) |-> {chan_status_out, dev_status_out, write_checksum_out} == 24'h008000;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_sum; reg_wr_in && !ck |=> write_checksum_out == $past(ns); endproperty
  a_sum: assert property (p_sum) else $error("bad checksum");
  property p_pre; reg_wr_in && ck |=> write_checksum_out == $past(reg_wdata_in); endproperty
  a_pre: assert property (p_pre) else $error("bad preset");
  property p_hold; !reg_wr_in |=> $stable(write_checksum_out); endproperty
  a_hold: assert property (p_hold) else $error("checksum moved");
  property p_rd; reg_rd_in |=> reg_rvalid_out && reg_rdata_out == $past(rs); endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_rv; !reg_rd_in |=> !reg_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("stray valid");
  // Sleep must power every channel down, so a sleep code beside a set bit is a fault.
  property p_slp; dev_status_out[7:5] == CSCR_MODE_SLEEP |-> chan_status_out == 8'h00; endproperty
  a_slp: assert property (p_slp) else $error("channel on in sleep");
  property p_act;
    dev_status_out[7:5] != CSCR_MODE_SLEEP |->
      dev_status_out[7:5] == (|chan_status_out ? CSCR_MODE_ACTIVE : CSCR_MODE_IDLE);
  endproperty
  a_act: assert property (p_act) else $error("bad mode");
endmodule : cscr_regs_props
bind cscr_regs cscr_regs_props u_cscr_regs_props (.clk_in, .sys_rst_in, .reg_wr_in,
  .reg_rd_in, .reg_page_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
  .chan_status_out, .dev_status_out, .write_checksum_out);
`default_nettype wire

// *** bench/cscr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cscr_host_model
(
  input  wire logic       clk_in,
  input  wire logic       reg_rvalid_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_page_out,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out
);
  initial {reg_wr_out, reg_rd_out, reg_page_out, reg_addr_out, reg_wdata_out} = 26'h0;
  // Released address and data flip so a stale value never passes for a fresh one.
  task automatic xfer(input logic w, input logic [23:0] pad, output logic [7:0] q,
    output logic ok);
    @(posedge clk_in);
    #1;
    {reg_wr_out, reg_rd_out, reg_page_out, reg_addr_out, reg_wdata_out} = {w, !w, pad};
    @(posedge clk_in);
    #1;
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {2'h0, ~pad[15:0]};
    {ok, q} = {w | reg_rvalid_in, reg_rdata_in};
  endtask : xfer
endmodule : cscr_host_model
`default_nettype wire

// *** bench/tb_cscr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_cscr_regs
  import cscr_pkg::*;
;
  logic        clk_in, sys_rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out, ok;
  logic        sleep_in, record_power_on_in, playback_power_on_in, bias_fault_down_in;
  logic        pll_enable_in, mic_bias_enable_in, boost_enable_in;
  logic [3:0]  rec_enable_in, play_enable_in, rec_fault_down_in;
  logic [7:0]  reg_page_in, reg_addr_in, reg_wdata_in, reg_rdata_out, q, s;
  logic [7:0]  chan_status_out, dev_status_out, write_checksum_out;
  logic [15:0] e;
  int          n_mismatch = 0;
  int          total_checks = 0;
  cscr_regs u_cscr_regs (.*);
  cscr_host_model u_cscr_host_model (.clk_in, .reg_rvalid_in(reg_rvalid_out),
    .reg_rdata_in(reg_rdata_out), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_page_out(reg_page_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    n_mismatch += int'(got !== exp);
    if (got !== exp)
      $display("Error %0t: read %h expected %h", $time, got, exp);
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // An unanswered read ends the run, since every later read would be misaligned.
  task automatic io(input logic w, input logic [23:0] pad);
    u_cscr_host_model.xfer(w, pad, q, ok);
    if (!w)
      chk({ok, q}, {1'b1, pad[7:0]});
    if (ok !== 1'b1)
      close_out();
  endtask : io
  task automatic apply(input logic [18:0] v);
    logic [3:0] r;
    logic [3:0] p;
    {sleep_in, record_power_on_in, playback_power_on_in, rec_enable_in, play_enable_in,
      rec_fault_down_in, bias_fault_down_in, pll_enable_in, mic_bias_enable_in,
      boost_enable_in} = v;
    r = v[15:12] & ~v[7:4] & {4{v[17] & ~v[18] & ~v[3]}};
    p = v[11:8] & {4{v[16] & ~v[18]}};
    e = {r[0], r[1], r[2], r[3], p[0], p[1], p[2], p[3], (v[18] ? 3'h4 : |{r, p} ? 3'h7 : 3'h6),
      v[2:0], |v[7:4], v[3]};
  endtask : apply
  task automatic t_reset;
    io(1'b0, 24'h007900);
    io(1'b0, 24'h007A80);
    io(1'b0, 24'h007E00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_status;
    logic [18:0] vec [7] = '{19'h7FF07, 19'h00004, 19'h21000, 19'h1F800, 19'h2F052, 19'h2F009,
      19'h20F00};
    foreach (vec[i])
    begin
      @(posedge clk_in);
      #1;
      apply(vec[i]);
      io(1'b0, {16'h0079, e[15:8]});
      io(1'b0, {16'h007A, e[7:0]});
    end
    $display("status test done");
  endtask : t_status
  task automatic t_sum;
    logic [23:0] w [4] = '{24'h031020, 24'h0079FF, 24'h007AFF, 24'h017EC3};
    s = 8'h55;
    io(1'b1, {16'h007E, s});
    foreach (w[i])
    begin
      io(1'b1, w[i]);
      s = s + w[i][15:8] + w[i][7:0];
    end
    io(1'b0, {16'h007E, s});
    io(1'b0, {16'h007A, e[7:0]});
    io(1'b0, {16'h0079, e[15:8]});
    io(1'b0, 24'h017A00);
    // A reset in mid-run must clear a checksum that the writes above left nonzero.
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    io(1'b0, 24'h007E00);
    $display("checksum test done");
  endtask : t_sum
  initial
  begin
    sys_rst_in = 1'b1;
    apply(19'h40000);
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_reset();
    t_status();
    t_sum();
    close_out();
  end
endmodule : tb_cscr_regs
`default_nettype wire
